// >>> pkg/oscs_regs.vh
// Register offsets, field positions, reset values and timing counts for the oscillator control.
`ifndef OSCS_REGS_VH
`define OSCS_REGS_VH
// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define OSCS_OSC_CONTROL_ADDR 12'h000
`define OSCS_FRC_TUNING_ADDR 12'h004
`define OSCS_AUX_CLOCK_ADDR 12'h008
`define OSCS_REFOUT_ADDR 12'h00c
`define OSCS_UNLOCK_ADDR 12'h010
// Key values written to the unlock register.
`define OSCS_UNLOCK_HIGH_KEY 32'h0000_0078
`define OSCS_UNLOCK_LOW_KEY 32'h0000_0046
// ----------------------------------------------------------------------
// Oscillator control register fields
// ----------------------------------------------------------------------
`define OSCS_CUR_LSB 12
`define OSCS_NXT_LSB 8
`define OSCS_LOCK_BIT 5
`define OSCS_CF_BIT 3
`define OSCS_SWREQ_BIT 0
// Source codes.
`define OSCS_SRC_FRC 3'h0
`define OSCS_SRC_INTERNAL_RC_WITH_PLL 3'h1
`define OSCS_SRC_PRI 3'h2
`define OSCS_SRC_PRIPLL 3'h3
`define OSCS_SRC_INTERNAL_SLOW_RC 3'h5
// ----------------------------------------------------------------------
// Auxiliary clock and reference output fields
// ----------------------------------------------------------------------
`define OSCS_AUX_ON_BIT 15
`define OSCS_AUX_LOCKED_BIT 14
`define OSCS_AUX_DIVSRC_BIT 13
`define OSCS_AUX_DIV_LSB 8
`define OSCS_AUX_PRI_BIT 7
`define OSCS_AUX_FRC_BIT 6
`define OSCS_RO_EN_BIT 15
`define OSCS_RO_SLEEP_BIT 13
`define OSCS_RO_SRC_BIT 12
`define OSCS_RO_DIV_LSB 8
`define OSCS_TUNE_RESET 6'h00
`define OSCS_AUX_RESET 16'h0000
`define OSCS_REFOUT_RESET 16'h0000
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define OSCS_SETTLE_CYCLES 4'ha
`endif

// >>> hdl/oscs_switch.v
// Oscillator switch, auxiliary clock and reference output control with an APB register slave.
// Function
// - Six-bit signed trim code tunes fast RC.
// - Auxiliary PLL on follows enable bit 15.
// - Bit 14 reads auxiliary PLL lock.
// - Bit 13 picks auxiliary divider source.
// - Three-bit auxiliary divider, 111 is one.
// - Aux PLL input: RC, primary, or none.
// - Reference pin driven only when enabled.
// - Reference keeps running in sleep if set.
// - Reference source crystal or system clock.
// - Reference divided by two to the field.
// - Switching allowed only when config bit zero.
// - Switching off: next still writable, current from config.
// - Switching off: request held low.
// - Equal current and next aborts switch.
// - Valid switch clears lock and fail flags.
// - Start oscillator, wait start-up or PLL lock.
// - Count ten source cycles before transfer.
// - Update current, clear request, stop old.
// - Clock failure traps and falls back to RC.
// - Source codes as fixed encoding.
// - Fail flag sticky until software or a valid switch clears.
// - Lock bit reflects PLL lock or timer; here PLL lock only, no timer.
`include "oscs_regs.vh"

module oscs_switch #(
  parameter AUX_DIV_W = 3, // Auxiliary divider code width.
  parameter REF_DIV_W = 4 // Reference divider code width.
) (
  input wire pclk, // APB clock, 40 MHz.
  input wire presetn, // Asynchronous reset, active low.
  input wire clk_en, // Clock enable; all state freezes while low.
  input wire psel, // APB select.
  input wire penable, // APB enable.
  input wire pwrite, // APB direction.
  input wire [11:0] paddr, // APB byte address.
  input wire [31:0] pwdata, // APB write data.
  output wire [31:0] prdata, // APB read data.
  output wire pready, // APB ready.
  output wire pslverr, // APB error on unmapped address.
  input wire switch_config_bit, // Clock switch config, 0 enables switching.
  input wire [2:0] initial_source_config, // Source chosen at reset.
  input wire wdt_enabled, // Watchdog enabled, keeps slow RC on.
  input wire sleep_mode, // Device in sleep.
  input wire primary_ready_pin, // Start-up timer expired, async.
  input wire pll_lock_pin, // Primary PLL lock, async.
  input wire aux_pll_lock_pin, // Auxiliary PLL lock, async.
  input wire osc_fail_pin, // Monitor detected oscillator failure, async.
  input wire new_src_tick, // One pulse per cycle of the new source.
  input wire sys_tick, // System clock tick for reference.
  input wire xtal_tick, // Crystal tick for reference.
  output reg [2:0] sys_source, // Source feeding the system clock.
  output reg clock_fail_trap, // One-cycle clock failure trap pulse.
  output reg [5:0] rc_trim_code, // Fast RC trim code.
  output reg primary_on, // Primary oscillator enable.
  output reg frc_on, // Fast RC enable.
  output reg internal_slow_rc_on, // Slow RC enable.
  output reg pll_on, // Primary PLL enable.
  output reg aux_pll_on, // Auxiliary PLL enable.
  output reg aux_divider_source, // 1 auxiliary oscillator path, 0 primary VCO.
  output reg [7:0] aux_div_ratio, // Auxiliary divide ratio minus one.
  output reg [1:0] aux_pll_input, // 2 fast RC, 1 primary, 0 none.
  output reg refout_pin, // Reference clock output.
  output reg refout_pin_oe // Reference output enable.
);

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  reg [3:0] sync1_r; // First stage, read only by second stage.
  reg [3:0] sync2_r; // Second stage.
  wire prim_rdy = sync2_r[0];
  wire pll_lk = sync2_r[1];
  wire aux_lk = sync2_r[2];
  wire fail_s = sync2_r[3];

  // Two flops per asynchronous input. Only the second stage feeds logic, so a
  // metastable first stage never reaches the sequencer; the price is two
  // cycles of latency on every lock, ready and failure level.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
    end else if (clk_en) begin
      sync1_r <= {osc_fail_pin, aux_pll_lock_pin, pll_lock_pin, primary_ready_pin};
      sync2_r <= sync1_r;
    end
  end

  // ----------------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------------
  // One-hot sequencer states; an illegal code falls back to idle through the
  // default branch rather than locking up the switch logic.
  localparam ST_IDLE = 4'h1; // No switch running.
  localparam ST_START = 4'h2; // Waiting for new source ready.
  localparam ST_SETTLE = 4'h4; // Counting new source cycles.
  localparam ST_DONE = 4'h8; // Transfer and clean up.

  reg [3:0] state_r; // Switch sequencer state.
  reg [2:0] cur_r; // Current source field.
  reg [2:0] nxt_r; // Next source field.
  reg swreq_r; // Switch request bit.
  reg cf_r; // Clock fail flag.
  reg lock_r; // PLL lock status bit.
  reg [3:0] settle_r; // Settle counter.
  reg [2:0] old_r; // Source being left.
  reg permit_hi_r; // Write permit for the high byte.
  reg permit_lo_r; // Write permit for the low byte.
  reg started_r; // Configuration loaded after reset.
  reg [15:0] aux_r; // Auxiliary control, writable bits only.
  reg [15:0] ref_r; // Reference output control.
  reg fail_d_r; // Delayed failure for edge detection.

  wire sw_en = ~switch_config_bit;
  wire wr = psel && penable && pwrite && clk_en;
  wire a_osc = (paddr == `OSCS_OSC_CONTROL_ADDR);
  wire a_tun = (paddr == `OSCS_FRC_TUNING_ADDR);
  wire a_aux = (paddr == `OSCS_AUX_CLOCK_ADDR);
  wire a_ref = (paddr == `OSCS_REFOUT_ADDR);
  wire a_unl = (paddr == `OSCS_UNLOCK_ADDR);
  wire mapped = a_osc | a_tun | a_aux | a_ref | a_unl;
  wire fail_evt = sw_en && fail_s && !fail_d_r;
  wire uses_pll = (nxt_r == `OSCS_SRC_INTERNAL_RC_WITH_PLL) || (nxt_r == `OSCS_SRC_PRIPLL);
  wire uses_pri = (nxt_r == `OSCS_SRC_PRI) || (nxt_r == `OSCS_SRC_PRIPLL);
  wire src_ready = (!uses_pri || prim_rdy) && (!uses_pll || pll_lk);
  wire cf_clr = wr && a_osc && permit_lo_r && !pwdata[`OSCS_CF_BIT];

  // Zero wait states: every access completes in its first access cycle.
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Sequencer and oscillator control register.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      cur_r <= `OSCS_SRC_FRC;
      nxt_r <= `OSCS_SRC_FRC;
      swreq_r <= 1'b0;
      cf_r <= 1'b0;
      lock_r <= 1'b0;
      settle_r <= 4'h0;
      old_r <= `OSCS_SRC_FRC;
      permit_hi_r <= 1'b0;
      permit_lo_r <= 1'b0;
      started_r <= 1'b0;
      fail_d_r <= 1'b0;
      clock_fail_trap <= 1'b0;
    end else if (clk_en) begin
      fail_d_r <= fail_s;
      clock_fail_trap <= fail_evt;
      // Lock reads PLL lock only when a PLL source is in use or wanted.
      // A lost lock therefore shows at once, not only at the next switch.
      lock_r <= pll_lk && (uses_pll || cur_r == `OSCS_SRC_INTERNAL_RC_WITH_PLL ||
                cur_r == `OSCS_SRC_PRIPLL);
      if (!started_r) begin
        // Straps are captured after reset release, never under reset.
        started_r <= 1'b1;
        cur_r <= initial_source_config;
        nxt_r <= initial_source_config;
      end
      // Permits come from the unlock register and are consumed on use.
      // Any control write burns both, so each byte needs a fresh unlock.
      if (wr && a_unl && pwdata == `OSCS_UNLOCK_HIGH_KEY) begin
        permit_hi_r <= 1'b1;
      end else if (wr && a_unl && pwdata == `OSCS_UNLOCK_LOW_KEY) begin
        permit_lo_r <= 1'b1;
      end
      if (wr && a_osc) begin
        permit_hi_r <= 1'b0;
        permit_lo_r <= 1'b0;
        if (permit_hi_r && state_r == ST_IDLE) begin
          nxt_r <= pwdata[`OSCS_NXT_LSB +: 3];
        end
        if (permit_lo_r && sw_en && pwdata[`OSCS_SWREQ_BIT] && state_r == ST_IDLE) begin
          swreq_r <= 1'b1;
        end
      end
      // Software clears the fail flag, but a new failure wins.
      if (cf_clr) begin
        cf_r <= 1'b0;
      end
      if (!sw_en) begin
        swreq_r <= 1'b0;
        state_r <= ST_IDLE;
      end else if (fail_evt) begin
        // Fall back to fast RC, keeping the PLL if it was in use.
        // A failure overrides any switch in flight and drops its request.
        cf_r <= 1'b1;
        old_r <= cur_r;
        cur_r <= (cur_r == `OSCS_SRC_PRIPLL || cur_r == `OSCS_SRC_INTERNAL_RC_WITH_PLL) ?
                 `OSCS_SRC_INTERNAL_RC_WITH_PLL : `OSCS_SRC_FRC;
        nxt_r <= (cur_r == `OSCS_SRC_PRIPLL || cur_r == `OSCS_SRC_INTERNAL_RC_WITH_PLL) ?
                 `OSCS_SRC_INTERNAL_RC_WITH_PLL : `OSCS_SRC_FRC;
        swreq_r <= 1'b0;
        state_r <= ST_IDLE;
      end else begin
        case (state_r)
          ST_IDLE: begin
            if (swreq_r) begin
              if (cur_r == nxt_r) begin
                swreq_r <= 1'b0;
              end else begin
                lock_r <= 1'b0;
                cf_r <= 1'b0;
                state_r <= ST_START;
              end
            end
          end
          ST_START: begin
            settle_r <= 4'h0;
            if (src_ready) begin
              state_r <= ST_SETTLE;
            end
          end
          // Counted in new source ticks, so a slow source stretches the wait.
          ST_SETTLE: begin
            if (new_src_tick) begin
              settle_r <= settle_r + 4'h1;
              if (settle_r == `OSCS_SETTLE_CYCLES - 4'h1) begin
                state_r <= ST_DONE;
              end
            end
          end
          ST_DONE: begin
            old_r <= cur_r;
            cur_r <= nxt_r;
            swreq_r <= 1'b0;
            state_r <= ST_IDLE;
          end
          default: begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Tuning, auxiliary and reference registers
  // ----------------------------------------------------------------------
  // Plain writes; the reference divider only changes while output is off.
  // Unwritable bits are masked on entry, so they read back as zero, except aux bit 14, which reads PLL lock.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rc_trim_code <= `OSCS_TUNE_RESET;
      aux_r <= `OSCS_AUX_RESET;
      ref_r <= `OSCS_REFOUT_RESET;
    end else if (wr) begin
      if (a_tun) begin
        rc_trim_code <= pwdata[5:0];
      end
      if (a_aux) begin
        aux_r <= pwdata[15:0] & 16'ha7c0;
      end
      if (a_ref) begin
        ref_r[15:12] <= pwdata[15:12] & 4'hb;
        if (!ref_r[`OSCS_RO_EN_BIT]) begin
          ref_r[11:8] <= pwdata[11:8];
        end
      end
    end
  end

  // Oscillator enables and auxiliary routing.
  // Start-up and lock are only observed here; no timer runs inside.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_source <= `OSCS_SRC_FRC;
      primary_on <= 1'b0;
      frc_on <= 1'b1;
      internal_slow_rc_on <= 1'b0;
      pll_on <= 1'b0;
      aux_pll_on <= 1'b0;
      aux_divider_source <= 1'b0;
      aux_div_ratio <= 8'h00;
      aux_pll_input <= 2'h0;
    end else if (clk_en) begin
      sys_source <= cur_r;
      // Old source stops when the new is current; slow RC kept if needed.
      primary_on <= (cur_r == `OSCS_SRC_PRI) || (cur_r == `OSCS_SRC_PRIPLL) ||
                    (state_r != ST_IDLE && uses_pri);
      pll_on <= (cur_r == `OSCS_SRC_INTERNAL_RC_WITH_PLL) || (cur_r == `OSCS_SRC_PRIPLL) ||
                (state_r != ST_IDLE && uses_pll);
      frc_on <= !((cur_r == `OSCS_SRC_PRI || cur_r == `OSCS_SRC_PRIPLL ||
                cur_r == `OSCS_SRC_INTERNAL_SLOW_RC) && !(state_r != ST_IDLE && !uses_pri));
      internal_slow_rc_on <= (cur_r == `OSCS_SRC_INTERNAL_SLOW_RC) || wdt_enabled || sw_en;
      aux_pll_on <= aux_r[`OSCS_AUX_ON_BIT];
      aux_divider_source <= aux_r[`OSCS_AUX_DIVSRC_BIT];
      // Code 7 divides by 1, each step down to code 1 doubles (64), 0 divides by 256.
      // Held as divisor minus one, the terminal count of a divider.
      aux_div_ratio <= (aux_r[10:8] == 3'h0) ? 8'hff :
                       ((8'h01 << (3'h7 - aux_r[10:8])) - 8'h01);
      aux_pll_input <= aux_r[`OSCS_AUX_FRC_BIT] ? 2'h2 :
                       (aux_r[`OSCS_AUX_PRI_BIT] ? 2'h1 : 2'h0);
    end
  end

  // ----------------------------------------------------------------------
  // Reference clock divider
  // ----------------------------------------------------------------------
  reg [14:0] ref_cnt_r; // Divider count in source ticks.
  wire ref_tick = ref_r[`OSCS_RO_SRC_BIT] ? xtal_tick : sys_tick;
  wire ref_run = ref_r[`OSCS_RO_EN_BIT] && (!sleep_mode || ref_r[`OSCS_RO_SLEEP_BIT]);
  // Half period is 2^(n-1) ticks; shifting by n first would overflow fifteen
  // bits at code fifteen and stall the divider.
  wire [14:0] half = 15'h0001 << (ref_r[11:8] - 4'h1);

  // Toggle every half period; field zero passes the tick level straight.
  // Stopping clears the count, so a restart begins with a full half period.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_cnt_r <= 15'h0000;
      refout_pin <= 1'b0;
      refout_pin_oe <= 1'b0;
    end else if (clk_en) begin
      refout_pin_oe <= ref_r[`OSCS_RO_EN_BIT];
      if (!ref_run) begin
        ref_cnt_r <= 15'h0000;
        refout_pin <= 1'b0;
      end else if (ref_r[11:8] == 4'h0) begin
        refout_pin <= ref_tick;
      end else if (ref_tick) begin
        if (ref_cnt_r >= half - 15'h0001) begin
          ref_cnt_r <= 15'h0000;
          refout_pin <= ~refout_pin;
        end else begin
          ref_cnt_r <= ref_cnt_r + 15'h0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  // Unused and reserved bits read as zero.
  reg [31:0] rd; // Read data.
  always @* begin
    rd = 32'h0000_0000;
    if (a_osc) begin
      rd[14:12] = cur_r;
      rd[10:8] = nxt_r;
      rd[`OSCS_LOCK_BIT] = lock_r;
      rd[`OSCS_CF_BIT] = cf_r;
      rd[`OSCS_SWREQ_BIT] = swreq_r;
    end else if (a_tun) begin
      rd[5:0] = rc_trim_code;
    end else if (a_aux) begin
      rd[15:0] = aux_r;
      rd[`OSCS_AUX_LOCKED_BIT] = aux_lk && aux_r[`OSCS_AUX_ON_BIT];
    end else if (a_ref) begin
      rd[15:0] = ref_r;
    end
  end
  // Read data is captured at the end of the setup phase and held through the
  // access phase; a status bit moving in between shows on the next read.
  reg [31:0] prdata_r; // Registered read data.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (clk_en && psel && !penable) begin
      prdata_r <= rd;
    end
  end
  assign prdata = prdata_r;

endmodule // oscs_switch

// >>> dv/oscs_switch_chk.sv
// Port-level assertions for the oscillator switch block.
`include "oscs_regs.vh"

// ----------------------------------------
// Checker
// ----------------------------------------
module oscs_switch_chk (
  input wire pclk, // Clock.
  input wire presetn, // Reset, active low.
  input wire clk_en, // Clock enable.
  input wire psel, // APB select.
  input wire penable, // APB enable.
  input wire pwrite, // APB direction.
  input wire [11:0] paddr, // APB address.
  input wire [31:0] pwdata, // APB write data.
  input wire pslverr, // APB error.
  input wire switch_config_bit, // Switch config.
  input wire [2:0] sys_source, // System source.
  input wire clock_fail_trap, // Failure trap.
  input wire [5:0] rc_trim_code, // Trim code.
  input wire aux_pll_on, // Aux PLL on.
  input wire aux_divider_source, // Aux divider source.
  input wire [7:0] aux_div_ratio, // Aux ratio minus one.
  input wire [1:0] aux_pll_input, // Aux PLL input.
  input wire refout_pin_oe // Reference enable.
);
  // Write data of the last two edges, so a field can be sliced after the fact.
  logic [31:0] wd_q;
  logic [31:0] wd_qq;
  wire wr = psel && penable && pwrite && clk_en; // A write is taken at this edge.
  // Divisor minus one for each aux divider code.
  function automatic logic [7:0] aux_ratio(input logic [2:0] c);
    aux_ratio = (c == 3'h0) ? 8'hff : (8'h01 << (3'h7 - c)) - 8'h01;
  endfunction
  always @(posedge pclk) begin
    wd_q <= pwdata;
    wd_qq <= wd_q;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_trim_write: assert property (wr && paddr == `OSCS_FRC_TUNING_ADDR |=>
    rc_trim_code == wd_q[5:0]) else $error("trim code not loaded");
  chk_aux_enable: assert property (wr && paddr == `OSCS_AUX_CLOCK_ADDR |=> ##1
    aux_pll_on == wd_qq[15]) else $error("aux pll enable wrong");
  chk_aux_divsrc: assert property (wr && paddr == `OSCS_AUX_CLOCK_ADDR |=> ##1
    aux_divider_source == wd_qq[13]) else $error("aux divider source wrong");
  chk_aux_ratio: assert property (wr && paddr == `OSCS_AUX_CLOCK_ADDR |=> ##1
    aux_div_ratio == aux_ratio(wd_qq[10:8])) else $error("aux ratio wrong");
  chk_aux_input: assert property (wr && paddr == `OSCS_AUX_CLOCK_ADDR |=> ##1
    aux_pll_input == (wd_qq[6] ? 2'h2 : {1'h0, wd_qq[7]})) else $error("aux input wrong");
  chk_refout_enable: assert property (wr && paddr == `OSCS_REFOUT_ADDR |=> ##1
    refout_pin_oe == wd_qq[15]) else $error("reference enable wrong");
  chk_unmapped_err: assert property (psel && penable && clk_en && paddr[1:0] == 2'h0 |->
    pslverr == (paddr > `OSCS_UNLOCK_ADDR)) else $error("slave error wrong");
  chk_no_trap_locked: assert property (switch_config_bit && $past(switch_config_bit) |->
    !clock_fail_trap) else $error("trap while monitor disabled");
  chk_trap_pulse: assert property (clock_fail_trap |=> !clock_fail_trap)
    else $error("trap longer than one cycle");
  chk_fail_to_rc: assert property (clock_fail_trap |-> ##[0:2]
    (sys_source == `OSCS_SRC_FRC || sys_source == `OSCS_SRC_INTERNAL_RC_WITH_PLL))
    else $error("no fallback to fast rc");
endmodule // oscs_switch_chk

bind oscs_switch oscs_switch_chk i_oscs_switch_chk (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
  .switch_config_bit(switch_config_bit), .sys_source(sys_source),
  .clock_fail_trap(clock_fail_trap), .rc_trim_code(rc_trim_code), .aux_pll_on(aux_pll_on),
  .aux_divider_source(aux_divider_source), .aux_div_ratio(aux_div_ratio),
  .aux_pll_input(aux_pll_input), .refout_pin_oe(refout_pin_oe)
);

// >>> dv/oscs_switch_tb_top.sv
// Self-checking testbench for the oscillator switch block.
`include "oscs_regs.vh"

module oscs_switch_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  logic switch_config_bit = 1'h1, sleep_mode = 1'h0, pll_lock_pin = 1'h0, se;
  logic aux_pll_lock_pin = 1'h0, osc_fail_pin = 1'h0, wdt_enabled = 1'h0;
  logic sys_tick = 1'h0, xtal_tick = 1'h0, new_src_tick = 1'h0;
  logic [2:0] initial_source_config = 3'h2; // Boot on the primary oscillator.
  wire [31:0] prdata;
  wire [2:0] sys_source;
  wire [5:0] rc_trim_code;
  wire [7:0] aux_div_ratio;
  wire [1:0] aux_pll_input;
  wire pready, pslverr, clock_fail_trap, primary_on, frc_on, internal_slow_rc_on, pll_on, aux_pll_on;
  wire aux_divider_source, refout_pin, refout_pin_oe;
  int error_cnt = 0;
  int cmp_count = 0;
  int tgl = 0; // Edges seen on the reference pin.
  int k;

  // Clock enable and start-up timer are tied; their gating is not exercised.
  oscs_switch i_oscs_switch (.pclk, .presetn, .clk_en(1'h1), .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .switch_config_bit, .initial_source_config,
    .wdt_enabled, .sleep_mode, .primary_ready_pin(1'h1), .pll_lock_pin,
    .aux_pll_lock_pin, .osc_fail_pin, .new_src_tick, .sys_tick, .xtal_tick, .sys_source,
    .clock_fail_trap, .rc_trim_code, .primary_on, .frc_on, .internal_slow_rc_on, .pll_on, .aux_pll_on,
    .aux_divider_source, .aux_div_ratio, .aux_pll_input, .refout_pin, .refout_pin_oe);

  always #12.5 pclk = ~pclk;
  always @(refout_pin) tgl++;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  // Compares one value; case inequality so an unknown never matches.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; it holds the request until pready is sampled high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd = prdata;
    se = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
    apb(1'h0, a, 32'h0);
    check(rd & m, exp);
  endtask
  // Unlock key followed by a control register write.
  task automatic osc_wr(input logic [31:0] key, input logic [31:0] d);
    apb(1'h1, `OSCS_UNLOCK_ADDR, key);
    apb(1'h1, `OSCS_OSC_CONTROL_ADDR, d);
  endtask
  // Pulses one tick input n times, one every other cycle, counting pin edges.
  task automatic pulse(input int s, input int n);
    tgl = 0;
    repeat (n) begin
      @(posedge pclk);
      sys_tick <= (s == 0);
      xtal_tick <= (s == 1);
      new_src_tick <= (s == 2);
      @(posedge pclk);
      {sys_tick, xtal_tick, new_src_tick} <= 3'h0;
    end
    repeat (4) @(posedge pclk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    rd_chk(`OSCS_FRC_TUNING_ADDR, 32'h0, 32'hffff);
    rd_chk(`OSCS_AUX_CLOCK_ADDR, 32'h0, 32'hffff);
    rd_chk(`OSCS_REFOUT_ADDR, 32'h0, 32'hffff);
    apb(1'h0, 12'h020, 32'h0);
    check(32'(se), 32'h1);
    for (k = 0; k < 2; k++) begin
      apb(1'h1, `OSCS_FRC_TUNING_ADDR, k ? 32'hffe0 : 32'h1f);
      rd_chk(`OSCS_FRC_TUNING_ADDR, k ? 32'h20 : 32'h1f, 32'hffff);
    end
  endtask
  // Every divider code, with the source-select bits walked alongside.
  task automatic t_aux;
    logic [31:0] d;
    for (k = 0; k < 8; k++) begin
      d = 32'h4000 | (k << 8) | (k[0] << 15) | (k[1] << 13) | (k[2] << 7) | (k[1] << 6);
      apb(1'h1, `OSCS_AUX_CLOCK_ADDR, d);
      repeat (2) @(negedge pclk);
      check(32'(aux_pll_on), 32'(k[0]));
      check(32'(aux_divider_source), 32'(k[1]));
      check(32'(aux_div_ratio), k ? (32'h1 << (7 - k)) - 1 : 32'hff);
      check(32'(aux_pll_input), k[1] ? 32'h2 : 32'(k[2]));
      rd_chk(`OSCS_AUX_CLOCK_ADDR, d & 32'ha7c0, 32'hffff);
    end
    aux_pll_lock_pin <= 1'h1;
    repeat (4) @(posedge pclk);
    rd_chk(`OSCS_AUX_CLOCK_ADDR, 32'h4000, 32'h4000);
  endtask
  task automatic t_ref;
    apb(1'h1, `OSCS_REFOUT_ADDR, 32'h9100); // Crystal source, divide by 2.
    apb(1'h1, `OSCS_REFOUT_ADDR, 32'h9300); // Divider change while enabled is refused.
    rd_chk(`OSCS_REFOUT_ADDR, 32'h9100, 32'hffff);
    check(32'(refout_pin_oe), 32'h1);
    pulse(1, 8);
    check(tgl, 8);
    pulse(0, 8);
    check(tgl, 0);
    sleep_mode <= 1'h1;
    pulse(1, 8);
    check(tgl, 0);
    apb(1'h1, `OSCS_REFOUT_ADDR, 32'hb100);
    pulse(1, 8);
    check(tgl, 8);
    sleep_mode <= 1'h0;
    apb(1'h1, `OSCS_REFOUT_ADDR, 32'h3100); // Disable before the divider changes.
    apb(1'h1, `OSCS_REFOUT_ADDR, 32'h8200);
    pulse(0, 8);
    check(tgl, 4);
    apb(1'h1, `OSCS_REFOUT_ADDR, 32'h0200);
    repeat (2) @(negedge pclk);
    check(32'(refout_pin_oe), 32'h0);
  endtask
  // Switching disabled: the request never sticks and the boot source stays.
  task automatic t_locked;
    osc_wr(`OSCS_UNLOCK_HIGH_KEY, 32'h0100);
    osc_wr(`OSCS_UNLOCK_LOW_KEY, 32'h0101);
    repeat (4) @(posedge pclk);
    rd_chk(`OSCS_OSC_CONTROL_ADDR, 32'h2000, 32'h7001);
    check(32'(sys_source), 32'h2);
    check(32'(primary_on), 32'h1);
    check(32'(frc_on), 32'h0);
    check(32'(internal_slow_rc_on), 32'h0);
    wdt_enabled <= 1'h1;
    repeat (2) @(posedge pclk);
    check(32'(internal_slow_rc_on), 32'h1);
    wdt_enabled <= 1'h0;
    switch_config_bit <= 1'h0;
    repeat (4) @(posedge pclk);
  endtask
  // A failure on the primary drops to the fast RC and leaves a sticky flag.
  task automatic t_fail;
    osc_fail_pin <= 1'h1;
    repeat (4) @(posedge pclk);
    osc_fail_pin <= 1'h0;
    repeat (12) @(posedge pclk);
    check(32'(sys_source), 32'(`OSCS_SRC_FRC));
    check(32'(primary_on), 32'h0);
    check(32'(frc_on), 32'h1);
    check(32'(internal_slow_rc_on), 32'h1);
    rd_chk(`OSCS_OSC_CONTROL_ADDR, 32'h0008, 32'h7008);
  endtask
  task automatic t_switch;
    osc_wr(`OSCS_UNLOCK_HIGH_KEY, 32'h0000);
    osc_wr(`OSCS_UNLOCK_LOW_KEY, 32'h0009); // Redundant request, flag bit kept.
    repeat (4) @(posedge pclk);
    rd_chk(`OSCS_OSC_CONTROL_ADDR, 32'h0008, 32'h7709);
    apb(1'h1, `OSCS_OSC_CONTROL_ADDR, 32'h0100); // No permit, so ignored.
    rd_chk(`OSCS_OSC_CONTROL_ADDR, 32'h0, 32'h0700);
    osc_wr(`OSCS_UNLOCK_HIGH_KEY, 32'h0100);
    osc_wr(`OSCS_UNLOCK_LOW_KEY, 32'h0109);
    rd_chk(`OSCS_OSC_CONTROL_ADDR, 32'h0101, 32'h7729);
    pulse(2, 12);
    check(32'(sys_source), 32'h0);
    pll_lock_pin <= 1'h1;
    repeat (4) @(posedge pclk);
    rd_chk(`OSCS_OSC_CONTROL_ADDR, 32'h0020, 32'h0020);
    pulse(2, 9);
    check(32'(sys_source), 32'h0);
    pulse(2, 1);
    check(32'(sys_source), 32'(`OSCS_SRC_INTERNAL_RC_WITH_PLL));
    rd_chk(`OSCS_OSC_CONTROL_ADDR, 32'h1100, 32'h7701);
    check(32'(pll_on), 32'h1);
  endtask

  // ----------------------------------------
  // Verdict and sequencing
  // ----------------------------------------
  task automatic report_and_stop;
    if (error_cnt == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    repeat (2) @(posedge pclk);
    t_regs();
    t_aux();
    t_ref();
    t_locked();
    t_fail();
    t_switch();
    report_and_stop();
  end
  // The whole run needs well under 100 us; a hang ends here.
  initial begin
    #200us;
    error_cnt++;
    report_and_stop();
  end
endmodule // oscs_switch_tb_top
